// file: common/sfi_pkg.sv
// shared constants and decode helpers for the serial flash id/register read link
package sfi_pkg;

  // ==========================================================
  // clock figures
  localparam int MCLK_HZ     = 40_000_000;
  localparam int SIG_MAX_HZ  = 50_000_000;
  localparam int FAST_MAX_HZ = 108_000_000;
  // host half period floor: two sync stages at each end plus edge detect
  localparam int HALF_MIN    = 8;

  // ==========================================================
  // identification table limits
  localparam int TBL_MAX = 256;

  // ==========================================================
  // opcodes
  localparam logic [7:0] OP_LEGACY_ID  = 8'h90;
  localparam logic [7:0] OP_ID_STRUCT  = 8'h9f;
  localparam logic [7:0] OP_SIGNATURE  = 8'hab;
  localparam logic [7:0] OP_PARAM      = 8'h5a;
  localparam logic [7:0] OP_STATUS_ONE = 8'h05;
  localparam logic [7:0] OP_STATUS_TWO = 8'h07;
  localparam logic [7:0] OP_CONFIG     = 8'h35;
  localparam logic [7:0] OP_BANK       = 8'h16;

  // ==========================================================
  // header lengths in serial clocks
  localparam logic [5:0] OPC_BITS   = 6'h08;
  localparam logic [5:0] ADDR_BITS  = 6'h18;
  localparam logic [5:0] DUMMY_BITS = 6'h08;
  localparam logic [2:0] LAST_BIT   = 3'h7;
  localparam logic [7:0] BYTE_ZERO  = 8'h00;

  // ==========================================================
  // header length of a command, opcode included
  function automatic logic [5:0] hdr_bits(input logic [7:0] op);
    case (op)
      OP_LEGACY_ID,
      OP_SIGNATURE: return OPC_BITS + ADDR_BITS;
      OP_PARAM:     return OPC_BITS + ADDR_BITS + DUMMY_BITS;
      default:      return OPC_BITS;
    endcase
  endfunction

  function automatic logic op_known(input logic [7:0] op);
    case (op)
      OP_LEGACY_ID, OP_ID_STRUCT, OP_SIGNATURE, OP_PARAM,
      OP_STATUS_ONE, OP_STATUS_TWO, OP_CONFIG, OP_BANK: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

endpackage

// file: common/sfi_if.sv
// serial link between the flash device end and the host controller end
interface sfi_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe;

  modport dev (
    input  cs_n,
    input  sck,
    input  si,
    output so,
    output so_oe
  );

  modport host (
    output cs_n,
    output sck,
    output si,
    input  so,
    input  so_oe
  );
endinterface

// file: rtl/sfi_flash_dev.sv
// flash device end: identification and register read command decoder
// ==========================================================
// Summary of operation
// - 90h plus 24-bit address then maker/device codes
// - legacy codes leave most significant bit first
// - address 000001h sends device code first
// - legacy codes alternate until chip select rises
// - 9Fh streams maker, device, extended, parameter bytes
// - 9Fh during busy operation is ignored
// - past table end, data is undefined
// - chip select high ends output and command
// - ABh plus three dummy bytes gives signature
// - signature repeats every eight further clocks
// - host keeps signature read at or below 50 MHz
// - 5Ah, address, eight dummies, then table bytes
// - parameter read address selects table start
// - 05h returns status one, even while busy
// - status one repeats, freshly sampled per byte
// - 07h returns status two, fresh per byte
// - 35h returns configuration, repeated per byte
// - 16h returns bank register, repeated per byte
module sfi_flash_dev
  import sfi_pkg::*;
#(
  // arbitrary neutral identity values
  parameter logic [7:0] MAKER_CODE     = 8'h5e,
  parameter logic [7:0] DEVICE_CODE    = 8'h3c,
  parameter logic [7:0] SIGNATURE_CODE = 8'h3c,
  parameter int         ID_LEN         = 8,
  parameter logic [ID_LEN*8-1:0] ID_STRUCT =
    {8'h5e, 8'h20, 8'h18, 8'h4d, 8'h01, 8'h80, 8'h30, 8'h00},
  parameter int         PT_LEN         = 8,
  parameter logic [PT_LEN*8-1:0] PT_STRUCT =
    {8'ha1, 8'hb2, 8'hc3, 8'hd4, 8'h00, 8'h01, 8'h01, 8'hff}
)(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rstn,
  // serial link
  sfi_if.dev              link,
  // device state
  input  wire logic       op_busy,
  input  wire logic [7:0] status_one,
  input  wire logic [7:0] status_two,
  input  wire logic [7:0] config_reg,
  input  wire logic [7:0] bank_reg
);

  // ==========================================================
  // elaboration checks
  initial begin
    if (ID_LEN < 4 || ID_LEN > TBL_MAX) begin
      $error("sfi_flash_dev: ID_LEN out of range");
    end
    if (PT_LEN < 1 || PT_LEN > TBL_MAX) begin
      $error("sfi_flash_dev: PT_LEN out of range");
    end
  end

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CMD  = 3'b001,
    ST_ADDR = 3'b011,
    ST_DATA = 3'b010,
    ST_SKIP = 3'b110
  } sfi_dev_state_type;

  sfi_dev_state_type state_reg;

  logic        cs_meta_reg;
  logic        cs_reg;
  logic        sck_meta_reg;
  logic        sck_reg;
  logic        sck_prev_reg;
  logic        si_meta_reg;
  logic        si_reg;
  logic [5:0]  cnt_reg;
  logic [7:0]  op_reg;
  logic [31:0] hsh_reg;
  logic [7:0]  ptr_reg;
  logic [2:0]  bit_reg;
  logic [7:0]  hold_reg;
  logic        so_reg;
  logic        oe_reg;

  logic        sck_rise;
  logic        sck_fall;
  logic [7:0]  op_next;
  logic [31:0] hsh_next;
  logic        hdr_enter;
  logic [7:0]  ptr_init;
  logic [7:0]  cur_byte;

  wire logic [TBL_MAX*8-1:0] id_tbl = (TBL_MAX*8)'(ID_STRUCT);
  wire logic [TBL_MAX*8-1:0] pt_tbl = (TBL_MAX*8)'(PT_STRUCT);

  // bytes past the table end read as zero; any value is allowed there
  function automatic logic [7:0] table_byte(
    input logic [TBL_MAX*8-1:0] tbl,
    input int                   len,
    input logic [7:0]           idx
  );
    if (int'(idx) < len) begin
      return tbl[(len-1-int'(idx))*8 +: 8];
    end
    return BYTE_ZERO;
  endfunction

  // ==========================================================
  // pin synchronisers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cs_meta_reg  <= 1'b1;
      cs_reg       <= 1'b1;
      sck_meta_reg <= 1'b0;
      sck_reg      <= 1'b0;
      sck_prev_reg <= 1'b0;
      si_meta_reg  <= 1'b0;
      si_reg       <= 1'b0;
    end else begin
      cs_meta_reg  <= link.cs_n;
      cs_reg       <= cs_meta_reg;
      sck_meta_reg <= link.sck;
      sck_reg      <= sck_meta_reg;
      sck_prev_reg <= sck_reg;
      si_meta_reg  <= link.si;
      si_reg       <= si_meta_reg;
    end
  end

  assign sck_rise = sck_reg & ~sck_prev_reg;
  assign sck_fall = ~sck_reg & sck_prev_reg;
  assign op_next  = {hsh_reg[6:0], si_reg};
  assign hsh_next = {hsh_reg[30:0], si_reg};

  // last header bit taken on this rising edge
  always_comb begin
    hdr_enter = 1'b0;
    if (sck_rise && !cs_reg) begin
      if (state_reg == ST_CMD && cnt_reg == OPC_BITS - 6'h01) begin
        hdr_enter = op_known(op_next) &&
                    !(op_next == OP_ID_STRUCT && op_busy) &&
                    hdr_bits(op_next) == OPC_BITS;
      end else if (state_reg == ST_ADDR) begin
        hdr_enter = (cnt_reg == 6'(hdr_bits(op_reg) - 6'h01));
      end
    end
  end

  // ==========================================================
  // command sequencing
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 6'h00;
      op_reg    <= BYTE_ZERO;
    end else if (cs_reg) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 6'h00;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          state_reg <= ST_CMD;
          cnt_reg   <= 6'h00;
        end
        ST_CMD: begin
          if (sck_rise) begin
            cnt_reg <= 6'(cnt_reg + 6'h01);
            if (cnt_reg == OPC_BITS - 6'h01) begin
              op_reg <= op_next;
              if (!op_known(op_next)) begin
                state_reg <= ST_SKIP;
              end else if (op_next == OP_ID_STRUCT && op_busy) begin
                state_reg <= ST_SKIP;
              end else if (hdr_enter) begin
                state_reg <= ST_DATA;
              end else begin
                state_reg <= ST_ADDR;
              end
            end
          end
        end
        ST_ADDR: begin
          if (sck_rise) begin
            cnt_reg <= 6'(cnt_reg + 6'h01);
            if (hdr_enter) begin
              state_reg <= ST_DATA;
            end
          end
        end
        ST_DATA: state_reg <= ST_DATA;
        ST_SKIP: state_reg <= ST_SKIP;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // header shift register, MSB first
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      hsh_reg <= 32'h0000_0000;
    end else if (state_reg == ST_IDLE) begin
      hsh_reg <= 32'h0000_0000;
    end else if (sck_rise && (state_reg == ST_CMD ||
                              state_reg == ST_ADDR)) begin
      hsh_reg <= hsh_next;
    end
  end

  // starting byte: legacy read picks order from address bit 0,
  // parameter read starts at the low address byte (dummies follow it)
  always_comb begin
    ptr_init = BYTE_ZERO;
    if (state_reg == ST_ADDR && op_reg == OP_LEGACY_ID) begin
      ptr_init = {7'h00, hsh_next[0]};
    end else if (state_reg == ST_ADDR && op_reg == OP_PARAM) begin
      ptr_init = hsh_next[15:8];
    end
  end

  // live inputs are sampled at each byte start, so status stays fresh
  always_comb begin
    unique case (op_reg)
      OP_LEGACY_ID:  cur_byte = ptr_reg[0] ? DEVICE_CODE
                                          : MAKER_CODE;
      OP_ID_STRUCT:  cur_byte = table_byte(id_tbl, ID_LEN,
                                           ptr_reg);
      OP_PARAM:      cur_byte = table_byte(pt_tbl, PT_LEN,
                                           ptr_reg);
      OP_SIGNATURE:  cur_byte = SIGNATURE_CODE;
      OP_STATUS_ONE: cur_byte = status_one;
      OP_STATUS_TWO: cur_byte = status_two;
      OP_CONFIG:     cur_byte = config_reg;
      OP_BANK:       cur_byte = bank_reg;
      default:       cur_byte = BYTE_ZERO;
    endcase
  end

  // ==========================================================
  // output shifter, changes on falling edges
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ptr_reg  <= BYTE_ZERO;
      bit_reg  <= 3'h0;
      hold_reg <= BYTE_ZERO;
      so_reg   <= 1'b0;
      oe_reg   <= 1'b0;
    end else if (state_reg != ST_DATA || cs_reg) begin
      bit_reg <= 3'h0;
      so_reg  <= 1'b0;
      oe_reg  <= 1'b0;
      if (hdr_enter) begin
        ptr_reg <= ptr_init;
      end
    end else if (sck_fall) begin
      oe_reg  <= 1'b1;
      bit_reg <= 3'(bit_reg + 3'h1);
      if (bit_reg == 3'h0) begin
        so_reg   <= cur_byte[LAST_BIT];
        hold_reg <= cur_byte;
        if (op_reg == OP_LEGACY_ID) begin
          ptr_reg <= ptr_reg ^ 8'h01;
        end else begin
          ptr_reg <= 8'(ptr_reg + 8'h01);
        end
      end else begin
        so_reg <= hold_reg[3'(LAST_BIT - bit_reg)];
      end
    end
  end

  assign link.so    = so_reg;
  assign link.so_oe = oe_reg;

endmodule

// file: rtl/sfi_flash_host.sv
// host controller end: frames one read command and collects its bytes
module sfi_flash_host
  import sfi_pkg::*;
#(
  parameter int HALF_CYCLES = 8
)(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // serial link
  sfi_if.host              link,
  // command request
  input  wire logic        start,
  input  wire logic [7:0]  opcode,
  input  wire logic [23:0] addr,
  input  wire logic [7:0]  rd_bytes,
  output logic             busy,
  // read data
  output logic             rd_valid,
  output logic [7:0]       rd_data,
  output logic             done
);

  // ==========================================================
  // elaboration checks
  initial begin
    if (HALF_CYCLES < HALF_MIN) begin
      $error("sfi_flash_host: HALF_CYCLES below sync latency");
    end
    // the half period divider is eight bits wide
    if (HALF_CYCLES > 256) begin
      $error("sfi_flash_host: HALF_CYCLES beyond divider width");
    end
    if (MCLK_HZ / (2 * HALF_CYCLES) > SIG_MAX_HZ) begin
      $error("sfi_flash_host: serial clock too fast");
    end
  end

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_RUN  = 2'b01,
    HS_STOP = 2'b11
  } sfi_host_state_type;

  localparam logic [7:0] HALF_LAST = 8'(HALF_CYCLES - 1);

  sfi_host_state_type state_reg;

  logic        cs_n_reg;
  logic        sck_reg;
  logic        si_reg;
  logic [39:0] tx_reg;
  logic [7:0]  div_reg;
  logic [11:0] rise_reg;
  logic [11:0] total_reg;
  logic [5:0]  hdr_reg;
  logic [7:0]  rx_reg;
  logic [7:0]  data_reg;
  logic        valid_reg;
  logic        done_reg;
  logic        so_meta_reg;
  logic        so_reg;
  logic        tick;
  logic [11:0] rx_idx;

  assign tick   = (div_reg == HALF_LAST);
  assign rx_idx = 12'(rise_reg - 12'(hdr_reg));

  // ==========================================================
  // data pin synchroniser
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      so_meta_reg <= 1'b0;
      so_reg      <= 1'b0;
    end else begin
      so_meta_reg <= link.so;
      so_reg      <= so_meta_reg;
    end
  end

  // ==========================================================
  // framing and clock divider
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= HS_IDLE;
      cs_n_reg  <= 1'b1;
      sck_reg   <= 1'b0;
      si_reg    <= 1'b0;
      tx_reg    <= 40'h00_0000_0000;
      div_reg   <= 8'h00;
      rise_reg  <= 12'h000;
      total_reg <= 12'h000;
      hdr_reg   <= 6'h00;
      done_reg  <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      div_reg  <= tick ? 8'h00 : 8'(div_reg + 8'h01);
      unique case (state_reg)
        HS_IDLE: begin
          div_reg <= 8'h00;
          if (start) begin
            state_reg <= HS_RUN;
            cs_n_reg  <= 1'b0;
            tx_reg    <= {opcode, addr, BYTE_ZERO};
            si_reg    <= opcode[LAST_BIT];
            hdr_reg   <= hdr_bits(opcode);
            total_reg <= 12'(hdr_bits(opcode)) +
                         {1'b0, rd_bytes, 3'h0};
            rise_reg  <= 12'h000;
          end
        end
        HS_RUN: begin
          if (tick && !sck_reg) begin
            sck_reg  <= 1'b1;
            rise_reg <= 12'(rise_reg + 12'h001);
            if (12'(rise_reg + 12'h001) == total_reg) begin
              state_reg <= HS_STOP;
            end
          end else if (tick) begin
            sck_reg <= 1'b0;
            tx_reg  <= {tx_reg[38:0], 1'b0};
            si_reg  <= tx_reg[38];
          end
        end
        HS_STOP: begin
          if (tick && sck_reg) begin
            sck_reg <= 1'b0;
          end else if (tick) begin
            cs_n_reg  <= 1'b1;
            si_reg    <= 1'b0;
            done_reg  <= 1'b1;
            state_reg <= HS_IDLE;
          end
        end
        default: state_reg <= HS_IDLE;
      endcase
    end
  end

  // ==========================================================
  // read collection on rising edges
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rx_reg    <= BYTE_ZERO;
      data_reg  <= BYTE_ZERO;
      valid_reg <= 1'b0;
    end else begin
      valid_reg <= 1'b0;
      if (state_reg == HS_RUN && tick && !sck_reg &&
          rise_reg >= 12'(hdr_reg)) begin
        rx_reg <= {rx_reg[6:0], so_reg};
        if (rx_idx[2:0] == LAST_BIT) begin
          data_reg  <= {rx_reg[6:0], so_reg};
          valid_reg <= 1'b1;
        end
      end
    end
  end

  assign busy      = (state_reg != HS_IDLE);
  assign rd_valid  = valid_reg;
  assign rd_data   = data_reg;
  assign done      = done_reg;
  assign link.cs_n = cs_n_reg;
  assign link.sck  = sck_reg;
  assign link.si   = si_reg;

endmodule

// file: verif/sfi_link_asserts.sv
// concurrent checks on the serial flash link between the two ends
module sfi_link_asserts (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // serial link
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  // ==========================================================
  // frame steps
  sequence frame_open;
    $fell(cs_n);
  endsequence

  // one idle half period before the first rising edge
  sequence lead_in;
    !sck [*8] ##1 sck;
  endsequence

  // eight mclk per half period keeps the link far below any limit
  sequence high_phase;
    sck [*8] ##1 !sck;
  endsequence

  // ==========================================================
  // checks
  lead_in_a: assert property (frame_open |-> lead_in)
    else $error("first clock rise not one half period after select");
  half_period_a: assert property ($rose(sck) |-> high_phase)
    else $error("serial clock high phase has the wrong length");
  idle_clock_a: assert property (cs_n && $past(cs_n) |-> !sck)
    else $error("serial clock moves outside a frame");
  si_hold_a: assert property (!cs_n && sck && $past(sck)
    |-> $stable(si))
    else $error("input line changes while clock is high");
  so_hold_a: assert property (so_oe && sck && $past(sck)
    |-> $stable(so))
    else $error("output line changes while clock is high");
  oe_start_a: assert property ($rose(so_oe) |-> !sck && !cs_n)
    else $error("output enable rises outside a low clock phase");
  oe_release_a: assert property ($rose(cs_n) |-> ##[1:5] !so_oe)
    else $error("output enable not released after deselect");
  oe_hold_a: assert property (so_oe && !cs_n |=> so_oe || cs_n)
    else $error("output stops while still selected");
  oe_quiet_a: assert property (cs_n [*6] |-> !so_oe)
    else $error("output driven while deselected");
endmodule

// file: verif/serial_flash_id_and_register_read_test.sv
// self-checking bench: host end and device end joined by one link
module serial_flash_id_and_register_read_test import sfi_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  // arbitrary identity values, not those of any real part
  localparam logic [7:0]  MK  = 8'h4b;
  localparam logic [7:0]  DV  = 8'h2d;
  localparam logic [7:0]  SG  = 8'h6e;
  localparam logic [63:0] IDS = {MK, DV, 48'h1841_0290_3007};
  localparam logic [63:0] PTS = 64'h9a8b_7c6d_5e4f_3021;

  logic        mclk, rstn, start, op_busy, busy, rd_valid, done, oe_seen;
  logic        cur_ok;
  logic [7:0]  opcode, rd_bytes, rd_data, status_one, status_two;
  logic [7:0]  config_reg, bank_reg, cur_op, k, n;
  logic [23:0] addr, cur_a, a;
  logic [7:0]  sv [16];
  logic [7:0]  ops [8];
  int          failures, comparisons, seed, j;

  sfi_if link ();

  sfi_flash_dev #(.MAKER_CODE(MK), .DEVICE_CODE(DV), .SIGNATURE_CODE(SG),
    .ID_LEN(8), .ID_STRUCT(IDS), .PT_LEN(8), .PT_STRUCT(PTS))
  sfi_flash_dev_inst (.mclk(mclk), .rstn(rstn), .link(link),
    .op_busy(op_busy), .status_one(status_one), .status_two(status_two),
    .config_reg(config_reg), .bank_reg(bank_reg));

  sfi_flash_host #(.HALF_CYCLES(8)) sfi_flash_host_inst (.mclk(mclk),
    .rstn(rstn), .link(link), .start(start), .opcode(opcode), .addr(addr),
    .rd_bytes(rd_bytes), .busy(busy), .rd_valid(rd_valid),
    .rd_data(rd_data), .done(done));

  sfi_link_asserts sfi_link_asserts_inst (.mclk(mclk), .rstn(rstn),
    .cs_n(link.cs_n), .sck(link.sck), .si(link.si), .so(link.so),
    .so_oe(link.so_oe));

  // ==========================================================
  // helpers
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // each register input gets its own view of the per-byte value
  task automatic put_status(input int i);
    status_one = sv[i];
    status_two = ~sv[i];
    config_reg = {sv[i][3:0], sv[i][7:4]};
    bank_reg = sv[i] + 8'h01;
  endtask

  function automatic logic [7:0] exp_byte(input int i);
    logic [7:0] s;
    int         ix;
    s = sv[i];
    ix = int'(cur_a[7:0]) + i;
    // a refused command leaves the data line parked low
    if (!cur_ok) return BYTE_ZERO;
    case (cur_op)
      OP_LEGACY_ID:  return (cur_a[0] ^ i[0]) ? DV : MK;
      OP_ID_STRUCT:  return (i < 8) ? IDS[(7 - i) * 8 +: 8] : BYTE_ZERO;
      OP_SIGNATURE:  return SG;
      OP_PARAM:      return (ix < 8) ? PTS[(7 - ix) * 8 +: 8] : BYTE_ZERO;
      OP_STATUS_ONE: return s;
      OP_STATUS_TWO: return ~s;
      OP_CONFIG:     return {s[3:0], s[7:4]};
      OP_BANK:       return s + 8'h01;
      default:       return BYTE_ZERO;
    endcase
  endfunction

  // one whole command frame, then a deselect gap for the device sync
  task automatic run_cmd(input logic [7:0] op, input logic [23:0] ad,
                         input logic [7:0] cnt, input logic bz);
    int   t;
    logic ok;
    ok = 1'b0;
    foreach (ops[i]) if (ops[i] == op) ok = 1'b1;
    if (op == OP_ID_STRUCT && bz) ok = 1'b0;
    for (int i = 0; i < 16; i++) sv[i] = 8'($random(seed));
    @(posedge mclk);
    #2;
    cur_op = op;
    cur_a = ad;
    cur_ok = ok;
    k = 8'h00;
    oe_seen = 1'b0;
    put_status(0);
    op_busy = bz;
    opcode = op;
    addr = ad;
    rd_bytes = cnt;
    start = 1'b1;
    @(posedge mclk);
    #2 start = 1'b0;
    check({7'h00, busy}, 8'h01);
    t = 0;
    while (done !== 1'b1 && t < 4000) begin
      @(negedge mclk);
      t++;
    end
    if (t >= 4000) failures++;
    check({7'h00, busy}, 8'h00);
    check(k, cnt);
    if (!ok || cnt != 8'h00) check({7'h00, oe_seen}, {7'h00, ok});
    repeat (6) @(posedge mclk);
    $display("command %h addr %h bytes %0d ended", op, ad, cnt);
  endtask

  // ==========================================================
  // byte monitor; fresh register values follow every received byte
  always @(posedge mclk) begin
    if (link.so_oe === 1'b1) oe_seen = 1'b1;
    if (rd_valid === 1'b1) begin
      check(rd_data, exp_byte(int'(k)));
      k = k + 8'h01;
      #2 put_status(int'(k));
    end
  end

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // longest frame is about 1420 cycles; the whole list stays far below this
  initial begin
    repeat (90000) @(posedge mclk);
    failures++;
    close_out();
  end

  // ==========================================================
  // main sequence
  initial begin
    seed = 45523;
    ops = '{OP_LEGACY_ID, OP_ID_STRUCT, OP_SIGNATURE, OP_PARAM,
            OP_STATUS_ONE, OP_STATUS_TWO, OP_CONFIG, OP_BANK};
    foreach (sv[i]) sv[i] = 8'h00;
    put_status(0);
    {start, op_busy, opcode, addr, rd_bytes} = '0;
    rstn = 1'b0;
    repeat (6) @(posedge mclk);
    #2 rstn = 1'b1;
    repeat (4) @(posedge mclk);
    run_cmd(OP_LEGACY_ID, 24'h000000, 8'h05, 1'b0);
    run_cmd(OP_LEGACY_ID, 24'h000001, 8'h04, 1'b0);
    run_cmd(OP_ID_STRUCT, 24'h000000, 8'h0a, 1'b0);
    run_cmd(OP_ID_STRUCT, 24'h000000, 8'h02, 1'b1);
    run_cmd(OP_ID_STRUCT, 24'h000000, 8'h02, 1'b0);
    run_cmd(OP_SIGNATURE, 24'h5a3c96, 8'h03, 1'b1);
    run_cmd(OP_PARAM, 24'hc30006, 8'h04, 1'b0);
    run_cmd(OP_PARAM, 24'h000000, 8'h02, 1'b0);
    for (int i = 4; i < 8; i++) begin
      run_cmd(ops[i], 24'h000000, 8'h03, 1'b1);
    end
    run_cmd(8'h03, 24'h000000, 8'h02, 1'b0);
    run_cmd(OP_STATUS_ONE, 24'h000000, 8'h00, 1'b0);
    for (int i = 0; i < 14; i++) begin
      j = int'($unsigned($random(seed)) % 8);
      a = 24'($random(seed));
      if (ops[j] == OP_PARAM) a[7:0] = a[7:0] % 8'h0a;
      if (ops[j] == OP_LEGACY_ID) a[23:1] = '0;
      n = 8'($unsigned($random(seed)) % 5);
      run_cmd(ops[j], a, n, 1'($random(seed)));
    end
    close_out();
  end
endmodule
